// file: core/mvl_capture_bank.sv
// snapshot bank of captured condition bits and program counter bytes
`timescale 1ns/1ps
`include "mvl_cfg.svh"

module mvl_capture_bank
(
   input  wire logic                       clk_sys,
   input  wire logic                       reset_n,
   input  wire logic                       load,
   input  wire logic [`MVL_PC_W-1:0]       pc_in,
   input  wire logic                       user_in,
   input  wire logic                       xmask_in,
   input  wire logic                       imask_in,
   input  wire logic [`MVL_BANK_IDX_W-1:0] rd_idx,
   output logic      [`MVL_DATA_W-1:0]     rd_data
);

   // packed bytes offered on a load, one per bank entry
   logic [`MVL_DATA_W-1:0] load_byte [`MVL_BANK_DEPTH];
   // stored entries
   logic [`MVL_DATA_W-1:0] entry_reg [`MVL_BANK_DEPTH];
   // index is legal
   wire                    idx_ok;

   // flag bytes keep only their documented bits, others zero
   always_comb
   begin
      load_byte[`MVL_IDX_FLAGS_HIGH]                 = `MVL_ZERO_BYTE;
      load_byte[`MVL_IDX_FLAGS_HIGH][`MVL_USER_BIT]  = user_in;
      load_byte[`MVL_IDX_FLAGS_LOW]                  = `MVL_ZERO_BYTE;
      load_byte[`MVL_IDX_FLAGS_LOW][`MVL_XMASK_BIT]  = xmask_in;
      load_byte[`MVL_IDX_FLAGS_LOW][`MVL_IMASK_BIT]  = imask_in;
      load_byte[`MVL_IDX_PC_HIGH]                    = pc_in[23:16];
      load_byte[`MVL_IDX_PC_MID]                     = pc_in[15:8];
      load_byte[`MVL_IDX_PC_LOW]                     = pc_in[7:0];
   end

   // every entry takes its byte on load only
   genvar gi;
   generate
      for (gi = 0; gi < `MVL_BANK_DEPTH; gi++)
      begin : g_entry
         always_ff @(posedge clk_sys or negedge reset_n)
         begin
            if (!reset_n)
               entry_reg[gi] <= `MVL_ZERO_BYTE;
            else if (load)
               entry_reg[gi] <= load_byte[gi];
         end
      end
   endgenerate

   assign idx_ok = (rd_idx < 3'(`MVL_BANK_DEPTH));

   // registered read port, zero for an index past the bank
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         rd_data <= `MVL_ZERO_BYTE;
      else
         rd_data <= idx_ok ? entry_reg[rd_idx] : `MVL_ZERO_BYTE;
   end

endmodule : mvl_capture_bank

// file: core/mvl_cfg.svh
// offsets, field positions and reset values of the mode and violation log
`ifndef MVL_CFG_SVH
`define MVL_CFG_SVH

// register bus geometry
`define MVL_ADDR_W          16
`define MVL_DATA_W          8

// register offsets
`define MVL_OFS_MODE        16'h0070
`define MVL_OFS_CODE_HIGH   16'h0080
`define MVL_OFS_CODE_LOW    16'h0081
`define MVL_OFS_FLAGS_HIGH  16'h0082
`define MVL_OFS_FLAGS_LOW   16'h0083
`define MVL_OFS_PC_HIGH     16'h0085
`define MVL_OFS_PC_MID      16'h0086
`define MVL_OFS_PC_LOW      16'h0087

// field positions
`define MVL_MODE_BIT        7
`define MVL_USER_BIT        7
`define MVL_XMASK_BIT       6
`define MVL_IMASK_BIT       4

// values
`define MVL_CLEAR_BYTE      8'hFF
`define MVL_ZERO_BYTE       8'h00
`define MVL_CODE_RESET      16'h0000
`define MVL_PC_W            24
`define MVL_PC_RESET        24'h000000

// capture bank geometry and read indices
`define MVL_BANK_DEPTH      5
`define MVL_BANK_IDX_W      3
`define MVL_IDX_FLAGS_HIGH  3'h0
`define MVL_IDX_FLAGS_LOW   3'h1
`define MVL_IDX_PC_HIGH     3'h2
`define MVL_IDX_PC_MID      3'h3
`define MVL_IDX_PC_LOW      3'h4

`endif

// file: core/mvl_mode_violation_log.sv
// chip mode register and access violation log with register port
`timescale 1ns/1ps
`include "mvl_cfg.svh"

// Functional notes
// - mode readable; only permitted writes take effect
// - mode bit reset value from strap pin
// - only special to normal single-chip allowed
// - high byte upper nibble holds initiator
// - high byte lower nibble holds target
// - low byte upper nibble holds access kind
// - low byte lower nibble holds violation class
// - code goes non-zero on core/ECC violation
// - counter and flags load with the code
// - non-zero code freezes code, counter, flags
// - writing all ones to both bytes clears
// - flags high bit 7 holds user state
// - flags low bit 6 holds xirq mask
// - flags low bit 4 holds irq mask
// - flags meaningless while code reads zero
// - counter holds faulting instruction address
// - counter and flags read-only, readable always
// - one global 16 MB address space
// - reset active low; strap latched at release
// - machine exception on core violation or ECC
module mvl_mode_violation_log
(
   input  wire logic                   clk_sys,
   input  wire logic                   reset_n,
   // strap pin choosing the start-up mode
   input  wire logic                   mode_select,
   // register port
   input  wire logic [`MVL_ADDR_W-1:0] reg_addr,
   input  wire logic [`MVL_DATA_W-1:0] reg_wdata,
   input  wire logic                   reg_write,
   input  wire logic                   reg_read,
   output logic      [`MVL_DATA_W-1:0] reg_rdata,
   // violation report from the bus fabric
   input  wire logic                   viol_valid,
   input  wire logic [3:0]             initiator_id,
   input  wire logic [3:0]             target_id,
   input  wire logic [3:0]             transfer_kind,
   input  wire logic [3:0]             fault_class,
   input  wire logic [`MVL_PC_W-1:0]   core_program_counter,
   input  wire logic                   core_user_state,
   input  wire logic                   core_xirq_mask,
   input  wire logic                   core_irq_mask,
   // status and requests toward the core
   output logic                        machine_exception,
   output logic                        normal_mode,
   output logic                        violation_logged
);

   // current operating mode bit, 0 special, 1 normal single-chip
   logic                   mode_reg;
   logic                   mode_next;
   // strap capture sequencer
   mvl_pkg::mvl_strap_t    strap_reg;
   mvl_pkg::mvl_strap_t    strap_next;
   // logged error code, high and low bytes
   logic [`MVL_DATA_W-1:0] code_high_reg;
   logic [`MVL_DATA_W-1:0] code_high_next;
   logic [`MVL_DATA_W-1:0] code_low_reg;
   logic [`MVL_DATA_W-1:0] code_low_next;
   // all-ones seen on each code byte since the last other write
   logic                   ones_high_reg;
   logic                   ones_high_next;
   logic                   ones_low_reg;
   logic                   ones_low_next;
   // registered read data of the plain registers
   logic [`MVL_DATA_W-1:0] rdata_reg;
   logic [`MVL_DATA_W-1:0] rdata_next;
   // read of the capture bank was issued last cycle
   logic                   bank_hit_reg;
   // exception request pulse
   logic                   exc_reg;

   // address decode
   wire                    sel_mode;
   wire                    sel_code_high;
   wire                    sel_code_low;
   wire                    sel_flags_high;
   wire                    sel_flags_low;
   wire                    sel_pc_high;
   wire                    sel_pc_mid;
   wire                    sel_pc_low;
   wire                    sel_bank;
   // write qualifiers
   wire                    wr_mode;
   wire                    wr_code_high;
   wire                    wr_code_low;
   wire                    wdata_ones;
   wire                    mode_upgrade;
   // violation qualifiers
   wire                    code_empty;
   wire                    core_fault;
   wire                    ecc_fault;
   wire                    loggable;
   wire                    log_now;
   wire                    clear_now;
   wire [`MVL_DATA_W-1:0]  event_high;
   wire [`MVL_DATA_W-1:0]  event_low;
   wire [`MVL_PC_W-1:0]    event_pc;
   // capture bank read side
   wire [2:0]              bank_idx;
   wire [`MVL_DATA_W-1:0]  bank_rdata;

   // register decode
   assign sel_mode       = (reg_addr == `MVL_OFS_MODE);
   assign sel_code_high  = (reg_addr == `MVL_OFS_CODE_HIGH);
   assign sel_code_low   = (reg_addr == `MVL_OFS_CODE_LOW);
   assign sel_flags_high = (reg_addr == `MVL_OFS_FLAGS_HIGH);
   assign sel_flags_low  = (reg_addr == `MVL_OFS_FLAGS_LOW);
   assign sel_pc_high    = (reg_addr == `MVL_OFS_PC_HIGH);
   assign sel_pc_mid     = (reg_addr == `MVL_OFS_PC_MID);
   assign sel_pc_low     = (reg_addr == `MVL_OFS_PC_LOW);
   assign sel_bank       = sel_flags_high | sel_flags_low |
                           sel_pc_high | sel_pc_mid | sel_pc_low;

   // write strobes per register; the bank has none
   assign wr_mode      = reg_write & sel_mode;
   assign wr_code_high = reg_write & sel_code_high;
   assign wr_code_low  = reg_write & sel_code_low;
   assign wdata_ones   = (reg_wdata == `MVL_CLEAR_BYTE);

   // only special to normal is honoured
   assign mode_upgrade = wr_mode & ~mode_reg & reg_wdata[`MVL_MODE_BIT];

   // violation classification
   assign code_empty = ({code_high_reg, code_low_reg} == `MVL_CODE_RESET);
   assign core_fault = (initiator_id == mvl_pkg::MVL_INIT_CORE);
   assign ecc_fault  = (fault_class == mvl_pkg::MVL_CLASS_ECC);
   assign loggable   = viol_valid & (core_fault | ecc_fault);

   // clear once both bytes have seen all ones, in either order
   assign clear_now = (wr_code_high & wdata_ones & (ones_low_reg | (wr_code_low & wdata_ones)))
                    | (wr_code_low & wdata_ones & ones_high_reg);

   // logging is open while empty or being cleared; the event wins
   assign log_now = loggable & (code_empty | clear_now);

   // code bytes assembled from the report fields
   assign event_high = {initiator_id, target_id};
   assign event_low  = {transfer_kind, fault_class};
   // faulting instruction address within the 16 MB map
   assign event_pc   = core_program_counter[`MVL_PC_W-1:0];

   // capture bank index from the read address
   assign bank_idx = sel_flags_high ? `MVL_IDX_FLAGS_HIGH :
                     sel_flags_low  ? `MVL_IDX_FLAGS_LOW  :
                     sel_pc_high    ? `MVL_IDX_PC_HIGH    :
                     sel_pc_mid     ? `MVL_IDX_PC_MID     :
                                      `MVL_IDX_PC_LOW;

   // snapshot bank, loaded with the code in the same cycle
   mvl_capture_bank u_bank
   (
      .clk_sys  (clk_sys),
      .reset_n  (reset_n),
      .load     (log_now),
      .pc_in    (event_pc),
      .user_in  (core_user_state),
      .xmask_in (core_xirq_mask),
      .imask_in (core_irq_mask),
      .rd_idx   (bank_idx),
      .rd_data  (bank_rdata)
   );

   // strap sequencer and mode next value
   always_comb
   begin
      strap_next = strap_reg;
      mode_next  = mode_reg;
      case (strap_reg)
         mvl_pkg::MVL_STRAP_WAIT:
         begin
            // first edge after release catches the pin
            mode_next  = mode_select;
            strap_next = mvl_pkg::MVL_STRAP_DONE;
         end
         mvl_pkg::MVL_STRAP_DONE:
         begin
            // other writes are dropped silently
            if (mode_upgrade)
               mode_next = 1'b1;
         end
         default:
         begin
            strap_next = mvl_pkg::MVL_STRAP_WAIT;
         end
      endcase
   end

   // error code next value
   always_comb
   begin
      code_high_next = code_high_reg;
      code_low_next  = code_low_reg;
      if (log_now)
      begin
         // a new violation, also when it meets a clear
         code_high_next = event_high;
         code_low_next  = event_low;
      end
      else if (clear_now)
      begin
         // both bytes to zero; bank contents become stale
         code_high_next = `MVL_ZERO_BYTE;
         code_low_next  = `MVL_ZERO_BYTE;
      end
   end

   // all-ones trackers: any other write to a byte forgets it
   always_comb
   begin
      ones_high_next = ones_high_reg;
      ones_low_next  = ones_low_reg;
      if (clear_now)
      begin
         ones_high_next = 1'b0;
         ones_low_next  = 1'b0;
      end
      else
      begin
         if (wr_code_high)
            ones_high_next = wdata_ones;
         if (wr_code_low)
            ones_low_next = wdata_ones;
      end
   end

   // read mux of the plain registers; reserved and unmapped read zero
   always_comb
   begin
      rdata_next = `MVL_ZERO_BYTE;
      if (reg_read)
      begin
         if (sel_mode)
            rdata_next[`MVL_MODE_BIT] = mode_reg;
         else if (sel_code_high)
            rdata_next = code_high_reg;
         else if (sel_code_low)
            rdata_next = code_low_reg;
         else
            rdata_next = `MVL_ZERO_BYTE;
      end
   end

   // mode and strap state
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         strap_reg <= mvl_pkg::MVL_STRAP_WAIT;
         mode_reg  <= 1'b0;
      end
      else
      begin
         strap_reg <= strap_next;
         mode_reg  <= mode_next;
      end
   end

   // error code bytes and clear trackers
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         code_high_reg <= `MVL_ZERO_BYTE;
         code_low_reg  <= `MVL_ZERO_BYTE;
         ones_high_reg <= 1'b0;
         ones_low_reg  <= 1'b0;
      end
      else
      begin
         code_high_reg <= code_high_next;
         code_low_reg  <= code_low_next;
         ones_high_reg <= ones_high_next;
         ones_low_reg  <= ones_low_next;
      end
   end

   // read data and bank select, valid the cycle after the strobe
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rdata_reg    <= `MVL_ZERO_BYTE;
         bank_hit_reg <= 1'b0;
      end
      else
      begin
         rdata_reg    <= rdata_next;
         bank_hit_reg <= reg_read & sel_bank;
      end
   end

   // exception request for every core violation or ECC fault
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         exc_reg <= 1'b0;
      else
         exc_reg <= loggable;
   end

   // outputs
   assign reg_rdata         = bank_hit_reg ? bank_rdata : rdata_reg;
   assign machine_exception = exc_reg;
   assign normal_mode       = mode_reg;
   assign violation_logged  = ~code_empty;

endmodule : mvl_mode_violation_log

// file: core/mvl_pkg.sv
// types for the mode and violation log
package mvl_pkg;

   // who caused the violation
   typedef enum logic [3:0] {
      MVL_INIT_NONE = 4'h0,
      MVL_INIT_CORE = 4'h1,
      MVL_INIT_ADC  = 4'h3
   } mvl_initiator_t;

   // target of the faulty access
   typedef enum logic [3:0] {
      MVL_TARGET_NONE     = 4'h0,
      MVL_TARGET_REGS     = 4'h1,
      MVL_TARGET_RAM      = 4'h2,
      MVL_TARGET_EEPROM   = 4'h3,
      MVL_TARGET_FLASH    = 4'h4,
      MVL_TARGET_INFO_NVM = 4'h5
   } mvl_target_t;

   // kind of the faulty access
   typedef enum logic [3:0] {
      MVL_KIND_NONE   = 4'h0,
      MVL_KIND_OPCODE = 4'h1,
      MVL_KIND_VECTOR = 4'h2,
      MVL_KIND_LOAD   = 4'h3,
      MVL_KIND_STORE  = 4'h4
   } mvl_kind_t;

   // class of violation
   typedef enum logic [3:0] {
      MVL_CLASS_NONE    = 4'h0,
      MVL_CLASS_ILLEGAL = 4'h1,
      MVL_CLASS_ECC     = 4'h2
   } mvl_class_t;

   // mode strap capture sequence
   typedef enum logic {
      MVL_STRAP_WAIT,
      MVL_STRAP_DONE
   } mvl_strap_t;

endpackage : mvl_pkg

// file: testbench/mvl_fabric_model.sv
// bus fabric model raising one-cycle violation reports
`timescale 1ns/1ps

module mvl_fabric_model
(
   input  wire logic        clk_sys,
   output logic             viol_valid,
   output logic [3:0]       initiator_id,
   output logic [3:0]       target_id,
   output logic [3:0]       transfer_kind,
   output logic [3:0]       fault_class,
   output logic [23:0]      core_program_counter,
   output logic             core_user_state,
   output logic             core_xirq_mask,
   output logic             core_irq_mask
);
   logic [42:0] bus_reg = 43'h0;   // packed report lines
   logic        busy = 1'b0;       // report on the wires

   assign {initiator_id, target_id, transfer_kind, fault_class, core_program_counter,
           core_user_state, core_xirq_mask, core_irq_mask} = bus_reg;

   initial viol_valid = 1'b0;

   // unqualified lines toggle each cycle so stale values never match
   always @(posedge clk_sys)
   begin
      if (!busy)
         bus_reg <= ~bus_reg;
   end

   // one report, valid for exactly one cycle
   task automatic report(input logic [42:0] f);
      busy = 1'b1;
      @(posedge clk_sys);
      viol_valid <= 1'b1;
      bus_reg    <= f;
      @(posedge clk_sys);
      viol_valid <= 1'b0;
      busy = 1'b0;
   endtask : report
endmodule : mvl_fabric_model

// file: testbench/mvl_mode_violation_log_tb.sv
// self-checking bench for the mode and violation log
`timescale 1ns/1ps
`include "mvl_cfg.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
   $display("Error at %0t ns: got %h want %h", $time, a, b); end end

module mvl_mode_violation_log_tb;
   logic        clk_sys = 1'b0;       // system clock
   logic        reset_n = 1'b0;       // reset, active low
   logic        mode_select = 1'b0;   // strap level
   logic [15:0] reg_addr = 16'h0000;  // register port
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_write = 1'b0;
   logic        reg_read = 1'b0;
   logic [7:0]  reg_rdata;
   logic [3:0]  initiator_id, target_id, transfer_kind, fault_class;
   logic [23:0] core_program_counter;
   logic        viol_valid, core_user_state, core_xirq_mask, core_irq_mask;
   logic        machine_exception, normal_mode, violation_logged;
   integer      seed = 57;            // fixed seed
   int          n_mismatch = 0;
   int          n_tests = 0;
   logic [7:0]  rd_val;               // last read data
   logic [42:0] first;                // report that must stay logged

   always #10 clk_sys = ~clk_sys;

   mvl_mode_violation_log dut
   (
      .clk_sys(clk_sys), .reset_n(reset_n), .mode_select(mode_select),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .viol_valid(viol_valid),
      .initiator_id(initiator_id), .target_id(target_id), .transfer_kind(transfer_kind),
      .fault_class(fault_class), .core_program_counter(core_program_counter),
      .core_user_state(core_user_state), .core_xirq_mask(core_xirq_mask),
      .core_irq_mask(core_irq_mask), .machine_exception(machine_exception),
      .normal_mode(normal_mode), .violation_logged(violation_logged)
   );
   mvl_fabric_model u_fab
   (
      .clk_sys(clk_sys), .viol_valid(viol_valid), .initiator_id(initiator_id),
      .target_id(target_id), .transfer_kind(transfer_kind), .fault_class(fault_class),
      .core_program_counter(core_program_counter), .core_user_state(core_user_state),
      .core_xirq_mask(core_xirq_mask), .core_irq_mask(core_irq_mask)
   );

   // random report; adc reports are always ecc class
   function automatic logic [42:0] draw(input logic adc);
      logic [3:0] t, k, c;
      t = 4'({$random(seed)} % 6);
      k = 4'({$random(seed)} % 5);
      c = adc ? 4'h2 : 4'({$random(seed)} % 2 + 1);
      draw = {adc ? 4'h3 : 4'h1, t, k, c, 24'($random(seed)), 3'($random(seed))};
   endfunction : draw

   // write; keep leaves the strobe up for a back-to-back write
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic keep);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      if (!keep)
      begin
         @(posedge clk_sys);
         reg_write <= 1'b0;
      end
   endtask : wr

   // read; data taken in the cycle after the strobe
   task automatic rd(input logic [15:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1;
      rd_val = reg_rdata;
   endtask : rd

   // reset with a given strap level
   task automatic do_reset(input logic m);
      @(posedge clk_sys);
      reset_n     <= 1'b0;
      mode_select <= m;
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK(normal_mode, m)
      `CHK(violation_logged, 1'b0)
      rd(`MVL_OFS_MODE);
      `CHK(rd_val, {m, 7'h00})
   endtask : do_reset

   // report and check exception and log flag
   task automatic send(input logic [42:0] f, input logic ex, input logic lg);
      u_fab.report(f);
      #1;
      `CHK(machine_exception, ex)
      `CHK(violation_logged, lg)
      @(posedge clk_sys);
      #1 `CHK(machine_exception, 1'b0)
   endtask : send

   // read every log register against a report
   task automatic check_log(input logic [42:0] f);
      rd(`MVL_OFS_CODE_HIGH);
      `CHK(rd_val, f[42:35])
      rd(`MVL_OFS_CODE_LOW);
      `CHK(rd_val, f[34:27])
      rd(`MVL_OFS_FLAGS_HIGH);
      `CHK(rd_val, {f[2], 7'h00})
      rd(`MVL_OFS_FLAGS_LOW);
      `CHK(rd_val, {1'b0, f[1], 1'b0, f[0], 4'h0})
      rd(`MVL_OFS_PC_HIGH);
      `CHK(rd_val, f[26:19])
      rd(`MVL_OFS_PC_MID);
      `CHK(rd_val, f[18:11])
      rd(`MVL_OFS_PC_LOW);
      `CHK(rd_val, f[10:3])
   endtask : check_log

   // counts and verdict, then stop
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict

   // main sequence
   initial
   begin
      do_reset(1'b0);
      wr(`MVL_OFS_MODE, 8'h7F, 1'b0);
      #1 `CHK(normal_mode, 1'b0)
      wr(`MVL_OFS_MODE, 8'h80, 1'b0);
      #1 `CHK(normal_mode, 1'b1)
      wr(`MVL_OFS_MODE, 8'h00, 1'b0);
      rd(`MVL_OFS_MODE);
      `CHK(rd_val, 8'h80)
      rd(16'h0084);
      `CHK(rd_val, 8'h00)
      rd(16'h0090);
      `CHK(rd_val, 8'h00)
      $display("test mode done");
      send({16'h3231, 27'h7FFFFFF}, 1'b0, 1'b0);
      $display("test ignored report done");
      for (int n = 0; n < 6; n++)
      begin
         first = draw(n[0]);
         send(first, 1'b1, 1'b1);
         wr(`MVL_OFS_PC_HIGH, ~first[26:19], 1'b0);
         wr(`MVL_OFS_FLAGS_LOW, 8'hFF, 1'b0);
         send(draw(~n[0]), 1'b1, 1'b1);
         check_log(first);
         if (n == 0)
         begin
            // a cancelled high byte must not pair with the low byte
            wr(`MVL_OFS_CODE_HIGH, 8'hFF, 1'b1);
            wr(`MVL_OFS_CODE_HIGH, 8'h00, 1'b0);
            wr(`MVL_OFS_CODE_LOW, 8'hFF, 1'b0);
            #1 `CHK(violation_logged, 1'b1)
            wr(`MVL_OFS_CODE_HIGH, 8'hFF, 1'b0);
         end
         else if (n[0])
         begin
            wr(`MVL_OFS_CODE_LOW, 8'hFF, 1'b1);
            wr(`MVL_OFS_CODE_HIGH, 8'hFF, 1'b0);
         end
         else
         begin
            wr(`MVL_OFS_CODE_HIGH, 8'hFF, 1'b1);
            wr(`MVL_OFS_CODE_LOW, 8'hFF, 1'b0);
         end
         #1 `CHK(violation_logged, 1'b0)
         rd(`MVL_OFS_CODE_LOW);
         `CHK(rd_val, 8'h00)
         $display("test log round %0d done", n);
      end
      send(draw(1'b0), 1'b1, 1'b1);
      do_reset(1'b1);
      $display("test second reset done");
      print_verdict;
   end

   // hang guard
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      print_verdict;
   end
endmodule : mvl_mode_violation_log_tb

bind mvl_mode_violation_log mvl_props u_props
(
   .clk_sys(clk_sys), .reset_n(reset_n), .mode_select(mode_select),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .reg_read(reg_read), .reg_rdata(reg_rdata), .viol_valid(viol_valid),
   .initiator_id(initiator_id), .target_id(target_id), .transfer_kind(transfer_kind),
   .fault_class(fault_class), .core_program_counter(core_program_counter),
   .core_user_state(core_user_state), .core_xirq_mask(core_xirq_mask),
   .core_irq_mask(core_irq_mask), .machine_exception(machine_exception),
   .normal_mode(normal_mode), .violation_logged(violation_logged)
);

// file: testbench/mvl_props.sv
// assertions on the ports of the mode and violation log
`timescale 1ns/1ps

module mvl_props
(
   input wire logic        clk_sys,
   input wire logic        reset_n,
   input wire logic        mode_select,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [7:0]  reg_rdata,
   input wire logic        viol_valid,
   input wire logic [3:0]  initiator_id,
   input wire logic [3:0]  target_id,
   input wire logic [3:0]  transfer_kind,
   input wire logic [3:0]  fault_class,
   input wire logic [23:0] core_program_counter,
   input wire logic        core_user_state,
   input wire logic        core_xirq_mask,
   input wire logic        core_irq_mask,
   input wire logic        machine_exception,
   input wire logic        normal_mode,
   input wire logic        violation_logged
);
   // loggable report: core initiator or ecc class
   wire       hit_w = viol_valid && (initiator_id == 4'h1 || fault_class == 4'h2);
   // the high code byte written with all ones
   wire       ffh_w = reg_write && reg_addr == 16'h0080 && reg_wdata == 8'hFF;
   logic [1:0] up_reg;   // masks the strap load after reset

   // shift in ones once reset is gone
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         up_reg <= 2'h0;
      else
         up_reg <= {up_reg[0], 1'b1};
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   exc_pulse_a: assert property (hit_w |=> machine_exception)
      else $error("exception missing after violation");
   exc_cause_a: assert property (machine_exception |-> $past(hit_w))
      else $error("exception without violation");
   log_set_a: assert property (hit_w |=> violation_logged)
      else $error("violation not logged");
   log_hold_a: assert property (violation_logged && !reg_write |=> violation_logged)
      else $error("log lost without write");
   log_rise_a: assert property ($rose(violation_logged) |-> $past(hit_w))
      else $error("log set without violation");
   clear_pair_a: assert property (reg_write && reg_addr == 16'h0081 && reg_wdata == 8'hFF
      && !hit_w && $past(ffh_w) |=> !violation_logged)
      else $error("clear pair did not clear");
   mode_keep_a: assert property (normal_mode |=> normal_mode)
      else $error("left normal mode");
   mode_rise_a: assert property (up_reg[1] && $rose(normal_mode) |->
      $past(reg_write && reg_addr == 16'h0070 && reg_wdata[7]))
      else $error("mode changed without write");
   mode_read_a: assert property (reg_read && reg_addr == 16'h0070 |=>
      reg_rdata == {normal_mode, 7'h00})
      else $error("mode read wrong");
   code_zero_a: assert property (reg_read && reg_addr[15:1] == 15'h0040
      && !violation_logged |=> reg_rdata == 8'h00)
      else $error("empty code reads non-zero");

   // main scenarios
   cover property (hit_w && !violation_logged);
   cover property (up_reg[1] && $rose(normal_mode));
   cover property ($fell(violation_logged));
endmodule : mvl_props
